// *** rtl/clkctl_defs.svh ***
// Offsets, field positions, reset values and timing for the clock control block
`ifndef CLKCTL_DEFS_SVH
`define CLKCTL_DEFS_SVH

// Register byte offsets
`define CFG_OFFSET       4'h4
`define INT_OFFSET       4'h8
`define RESET_VALUE      32'h0000_0000

// Configuration register fields
`define SLOW_DIV_HI      10
`define SLOW_DIV_LO      8
`define FAST_DIV_HI      7
`define FAST_DIV_LO      4
`define STATUS_HI        3
`define STATUS_LO        2
`define SELECT_HI        1
`define SELECT_LO        0

// Interrupt register fields
`define CLEAR_HI         23
`define CLEAR_LO         16
`define ENABLE_HI        14
`define ENABLE_LO        8
`define STUCK_BIT        7
`define FLAG_HI          6
`define FLAG_LO          0

// Source codes
`define SRC_RC8          2'h0
`define SRC_CRYSTAL      2'h1
`define SRC_LOOP         2'h2
`define SRC_RESERVED     2'h3

// Stable input positions
`define STB_RC8          2
`define STB_CRYSTAL      3
`define STB_LOOP         4

// Switch settle time and clock rate
`define SETTLE_NS        200
`define CLK_PERIOD_NS    25
`define SETTLE_CYC       4'(((`SETTLE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SETTLE_LAST      4'(`SETTLE_CYC - 4'h1)

// Divider ratios as shift amounts
`define SLOW_LOG_BASE    4'h1
`define FAST_LOG_LOW     4'h1
`define FAST_LOG_HIGH    4'h6

`endif

// *** rtl/clkctl_pkg.sv ***
// Types shared by the clock control block
package clkctl_pkg;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_SETTLE} sw_state_e;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] o;
  } sync_s;

  typedef struct packed {
    logic [8:0] cnt;
  } div_s;

  typedef struct packed {
    logic [2:0]  slow_div;
    logic [3:0]  fast_div;
    logic [1:0]  sel;
    logic [1:0]  status;
    sw_state_e   sw;
    logic [3:0]  settle;
    logic [1:0]  target;
    logic [6:0]  en;
    logic        stuck;
    logic [6:0]  flags;
    logic [7:0]  seen;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        fast_en;
    logic        slow_en;
  } top_s;

endpackage

// *** rtl/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Levels
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);

  sync_s      st_r;
  sync_s      st_nxt;
  logic [7:0] o_nxt;

  // Output follows the second stage once the third agrees
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign o_nxt[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s2[i] : st_r.o[i];
    end
  endgenerate

  // Stage shift
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.o  = o_nxt;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.o;

endmodule
`default_nettype wire

// *** rtl/pow2_divider.sv ***
// Power-of-two enable divider: one pulse per 2**ratio_log2 input enables
`timescale 1ns/1ps
`default_nettype none
module pow2_divider
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Input enable and ratio
  input  wire logic       ce,
  input  wire logic [3:0] ratio_log2,
  output logic            pulse
);

  div_s       st_r;
  div_s       st_nxt;
  logic [8:0] mask;

  // Mask of low counter bits that must all be set
  assign mask  = 9'((10'h001 << ratio_log2) - 10'h001);
  assign pulse = ce && ((st_r.cnt & mask) == mask);

  // Count input enables
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.cnt = st_r.cnt + 9'h001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// *** rtl/clock_control.sv ***
// Bus prescalers, system clock source switch and clock interrupt register
// What this block does
// - Slow bus divider: pass, or divide 2..16
// - Fast bus divider: pass, 2..16, 64..512
// - Status field shows source really clocking system
// - Select field requests rc8, crystal or loop
// - Status updates only after switch completes or on a forced return to rc8
// - Low-power exit forces rc8 oscillator
// - Crystal failure under crystal use forces rc8
// - Write-one clear bits 23..16, write-only
// - Bits 14..8 enable each stabilization interrupt
// - Stuck flag set by hardware, cleared by bit 23
// - Interrupt register at 0x08, resets zero
// - Stable flags set when enabled, cleared by writes
//
// The Avalon-MM register port was chosen for this implementation.
`include "clkctl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_control
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Oscillator status, asynchronous
  input  wire logic [6:0]  SOURCE_STABLE,
  input  wire logic        CRYSTAL_STUCK,
  // Power and loop context, same clock
  input  wire logic        LOW_POWER_EXIT,
  input  wire logic        LOOP_FROM_CRYSTAL,
  // Clock steering
  output logic      [1:0]  SYSCLK_SOURCE,
  output logic             FAST_BUS_EN,
  output logic             SLOW_BUS_EN,
  output logic             CLOCK_IRQ
);

  top_s        st_r;
  top_s        st_nxt;
  logic [7:0]  sync_lvl;
  logic [7:0]  rise;
  logic        fast_pulse;
  logic        slow_pulse;
  logic [3:0]  fast_log;
  logic [3:0]  slow_log;
  logic        req;
  logic        wr_go;
  logic        cfg_hit;
  logic        int_hit;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [7:0]  clr;
  logic        crystal_used;
  logic        force_rc8;
  logic        target_stable;

  // Asynchronous oscillator levels
  pin_sync u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   ({CRYSTAL_STUCK, SOURCE_STABLE}),
    .dout  (sync_lvl)
  );

  // Divider ratios from the prescaler fields
  always_comb begin
    if (!st_r.fast_div[3]) begin
      fast_log = 4'h0;
    end else if (st_r.fast_div[2]) begin
      fast_log = `FAST_LOG_HIGH + {2'h0, st_r.fast_div[1:0]};
    end else begin
      fast_log = `FAST_LOG_LOW + {2'h0, st_r.fast_div[1:0]};
    end
    if (!st_r.slow_div[2]) begin
      slow_log = 4'h0;
    end else begin
      slow_log = `SLOW_LOG_BASE + {2'h0, st_r.slow_div[1:0]};
    end
  end

  // Fast bus from system clock, slow bus from fast bus
  pow2_divider u_fast (
    .clk        (SYS_CLK),
    .rst_n      (RST_N),
    .ce         (1'b1),
    .ratio_log2 (fast_log),
    .pulse      (fast_pulse)
  );

  pow2_divider u_slow (
    .clk        (SYS_CLK),
    .rst_n      (RST_N),
    .ce         (fast_pulse),
    .ratio_log2 (slow_log),
    .pulse      (slow_pulse)
  );

  // Bus decode: one wait state per access
  assign req     = AVS_READ || AVS_WRITE;
  assign wr_go   = AVS_WRITE && st_r.ack;
  assign cfg_hit = AVS_ADDRESS == `CFG_OFFSET;
  assign int_hit = AVS_ADDRESS == `INT_OFFSET;
  assign wmask   = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wdata   = AVS_WRITEDATA & wmask;
  assign clr     = (wr_go && int_hit) ? wdata[`CLEAR_HI:`CLEAR_LO] : 8'h00;

  // Rising edges of synchronised levels
  assign rise = sync_lvl & ~st_r.seen;

  // Crystal feeds the system clock directly or through the loop, or is the target of a switch under way
  assign crystal_used = (st_r.status == `SRC_CRYSTAL) ||
                        (st_r.status == `SRC_LOOP && LOOP_FROM_CRYSTAL) ||
                        (st_r.sw != SW_IDLE && st_r.target == `SRC_CRYSTAL);
  assign force_rc8    = LOW_POWER_EXIT || (sync_lvl[7] && crystal_used);

  // Requested source has settled its oscillator
  always_comb begin
    case (st_r.target)
      `SRC_RC8:     target_stable = sync_lvl[`STB_RC8];
      `SRC_CRYSTAL: target_stable = sync_lvl[`STB_CRYSTAL];
      `SRC_LOOP:    target_stable = sync_lvl[`STB_LOOP];
      default:      target_stable = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_nxt         = st_r;
    st_nxt.seen    = sync_lvl;
    st_nxt.ack     = req && !st_r.ack;
    st_nxt.fast_en = fast_pulse;
    st_nxt.slow_en = slow_pulse;

    // Configuration writes
    if (wr_go && cfg_hit) begin
      if (AVS_BYTEENABLE[1]) begin
        st_nxt.slow_div = wdata[`SLOW_DIV_HI:`SLOW_DIV_LO];
      end
      if (AVS_BYTEENABLE[0]) begin
        st_nxt.fast_div = wdata[`FAST_DIV_HI:`FAST_DIV_LO];
        if (wdata[`SELECT_HI:`SELECT_LO] != `SRC_RESERVED) begin
          st_nxt.sel    = wdata[`SELECT_HI:`SELECT_LO];
          st_nxt.target = wdata[`SELECT_HI:`SELECT_LO];
          st_nxt.sw     = SW_WAIT;
        end
      end
    end

    // Switch sequence: wait for oscillator, settle, then report
    case (st_r.sw)
      SW_IDLE: begin
      end
      SW_WAIT: begin
        if (target_stable && st_nxt.sw == SW_WAIT) begin
          st_nxt.sw     = SW_SETTLE;
          st_nxt.settle = `SETTLE_LAST;
        end
      end
      SW_SETTLE: begin
        if (st_nxt.sw == SW_SETTLE) begin
          if (!target_stable) begin
            st_nxt.sw = SW_WAIT;
          end else if (st_r.settle == 4'h0) begin
            st_nxt.status = st_r.target;
            st_nxt.sw     = SW_IDLE;
          end else begin
            st_nxt.settle = st_r.settle - 4'h1;
          end
        end
      end
      default: begin
        st_nxt.sw = SW_IDLE;
      end
    endcase

    // Forced return to the rc8 oscillator wins over any switch
    if (force_rc8) begin
      st_nxt.sel    = `SRC_RC8;
      st_nxt.status = `SRC_RC8;
      st_nxt.target = `SRC_RC8;
      st_nxt.sw     = SW_IDLE;
    end

    // Interrupt enables
    if (wr_go && int_hit && AVS_BYTEENABLE[1]) begin
      st_nxt.en = wdata[`ENABLE_HI:`ENABLE_LO];
    end

    // Flags: set wins over clear
    st_nxt.stuck = (st_r.stuck && !clr[7]) || rise[7];
    st_nxt.flags = (st_r.flags & ~clr[6:0]) | (rise[6:0] & st_r.en);
    st_nxt.irq   = st_nxt.stuck || (|st_nxt.flags);

    // Read data captured in the wait cycle
    if (AVS_READ && !st_r.ack) begin
      if (cfg_hit) begin
        st_nxt.rdata = {21'h0, st_r.slow_div, st_r.fast_div, st_r.status, st_r.sel};
      end else if (int_hit) begin
        st_nxt.rdata = {16'h0, 1'b0, st_r.en, st_r.stuck, st_r.flags};
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end
  end

  // State register, all zero at reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign AVS_READDATA    = st_r.rdata;
  assign AVS_WAITREQUEST = req && !st_r.ack;
  assign SYSCLK_SOURCE   = st_r.status;
  assign FAST_BUS_EN     = st_r.fast_en;
  assign SLOW_BUS_EN     = st_r.slow_en;
  assign CLOCK_IRQ       = st_r.irq;

  // Checks
  sequence s_enter_settle;
    st_r.sw == SW_WAIT ##1 st_r.sw == SW_SETTLE;
  endsequence

  sequence s_clear_stuck;
    wr_go && int_hit && AVS_BYTEENABLE[2] && AVS_WRITEDATA[`CLEAR_HI];
  endsequence

  property p_slow_pass;
    @(posedge SYS_CLK) disable iff (!RST_N)
    !st_r.slow_div[2] |=> (SLOW_BUS_EN == FAST_BUS_EN);
  endproperty
  a_slow_pass: assert property (p_slow_pass) else $error("slow bus not undivided");

  property p_fast_half;
    @(posedge SYS_CLK) disable iff (!RST_N)
    ($past(st_r.fast_div) == 4'h8 && $past(st_r.fast_div, 2) == 4'h8)
      |-> (FAST_BUS_EN != $past(FAST_BUS_EN));
  endproperty
  a_fast_half: assert property (p_fast_half) else $error("fast bus not half rate");

  property p_status_cause;
    @(posedge SYS_CLK) disable iff (!RST_N)
    $changed(SYSCLK_SOURCE) |->
      $past(force_rc8) || ($past(st_r.sw) == SW_SETTLE && $past(st_r.settle) == 4'h0);
  endproperty
  a_status_cause: assert property (p_status_cause) else $error("status moved early");

  property p_settle_bound;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_enter_settle |-> ##[1:8] (st_r.sw != SW_SETTLE);
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settle too long");

  property p_low_power;
    @(posedge SYS_CLK) disable iff (!RST_N)
    LOW_POWER_EXIT |=> (st_r.sel == `SRC_RC8 && SYSCLK_SOURCE == `SRC_RC8);
  endproperty
  a_low_power: assert property (p_low_power) else $error("no rc8 after wake");

  property p_stuck_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
    st_r.stuck && !clr[7] |=> st_r.stuck;
  endproperty
  a_stuck_hold: assert property (p_stuck_hold) else $error("stuck flag lost");

  property p_clear;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (clr[0] && !rise[0]) |=> !st_r.flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_flag_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (rise[4] && st_r.en[4]) |=> st_r.flags[4];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("loop flag not set");

  property p_irq;
    @(posedge SYS_CLK) disable iff (!RST_N)
    CLOCK_IRQ == (st_r.stuck || (|st_r.flags));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // Clear strobe with no new stuck edge empties the flag
  property p_stuck_clear;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_clear_stuck ##0 !rise[7] |=> !st_r.stuck;
  endproperty
  a_stuck_clear: assert property (p_stuck_clear) else $error("stuck flag not cleared");

  property p_stuck_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
    rise[7] |=> st_r.stuck;
  endproperty
  a_stuck_set: assert property (p_stuck_set) else $error("stuck flag not set");

  property p_status_legal;
    @(posedge SYS_CLK) disable iff (!RST_N)
    SYSCLK_SOURCE != `SRC_RESERVED;
  endproperty
  a_status_legal: assert property (p_status_legal) else $error("reserved status shown");

  // Exactly one wait state per access
  property p_one_wait;
    @(posedge SYS_CLK) disable iff (!RST_N)
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state too long");

  property p_crystal_force;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (sync_lvl[7] && SYSCLK_SOURCE == `SRC_CRYSTAL)
      |=> (SYSCLK_SOURCE == `SRC_RC8 && st_r.sel == `SRC_RC8);
  endproperty
  a_crystal_force: assert property (p_crystal_force) else $error("no rc8 after failure");

  property p_enable_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (wr_go && int_hit && AVS_BYTEENABLE[1])
      |=> st_r.en == $past(AVS_WRITEDATA[`ENABLE_HI:`ENABLE_LO]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enables not written");

  // Reserved select code leaves the request untouched
  property p_resv_ignored;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (wr_go && cfg_hit && AVS_BYTEENABLE[0] && !force_rc8 &&
     AVS_WRITEDATA[`SELECT_HI:`SELECT_LO] == `SRC_RESERVED)
      |=> ($stable(st_r.sel) && $stable(st_r.target));
  endproperty
  a_resv_ignored: assert property (p_resv_ignored) else $error("reserved select taken");

  property p_clear_zero;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && int_hit)
      |-> AVS_READDATA[`CLEAR_HI:`CLEAR_LO] == 8'h00;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear bits readable");

endmodule
`default_nettype wire

// *** testbench/clock_control_tb.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`include "clkctl_defs.svh"
`default_nettype none
module clock_control_tb
  import clkctl_pkg::*;
;
  typedef struct {
    string       nm;
    logic [31:0] e;
    logic [31:0] m;
  } note_s;

  logic        SYS_CLK;
  logic        RST_N;
  logic [3:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [6:0]  SOURCE_STABLE;
  logic        CRYSTAL_STUCK;
  logic        LOW_POWER_EXIT;
  logic        LOOP_FROM_CRYSTAL;
  logic [1:0]  SYSCLK_SOURCE;
  logic        FAST_BUS_EN;
  logic        SLOW_BUS_EN;
  logic        CLOCK_IRQ;
  logic [31:0] rd;
  logic [6:0]  en;
  logic [6:0]  cl;
  logic [2:0]  sl;
  note_s       q[$];
  note_s       n;
  int          fail_count;
  int          num_checks;
  int          cyc = 0;
  int          fp;
  int          sp;

  clock_control dut_u (
    .SYS_CLK          (SYS_CLK),
    .RST_N            (RST_N),
    .AVS_ADDRESS      (AVS_ADDRESS),
    .AVS_READ         (AVS_READ),
    .AVS_WRITE        (AVS_WRITE),
    .AVS_WRITEDATA    (AVS_WRITEDATA),
    .AVS_BYTEENABLE   (AVS_BYTEENABLE),
    .AVS_READDATA     (AVS_READDATA),
    .AVS_WAITREQUEST  (AVS_WAITREQUEST),
    .SOURCE_STABLE    (SOURCE_STABLE),
    .CRYSTAL_STUCK    (CRYSTAL_STUCK),
    .LOW_POWER_EXIT   (LOW_POWER_EXIT),
    .LOOP_FROM_CRYSTAL(LOOP_FROM_CRYSTAL),
    .SYSCLK_SOURCE    (SYSCLK_SOURCE),
    .FAST_BUS_EN      (FAST_BUS_EN),
    .SLOW_BUS_EN      (SLOW_BUS_EN),
    .CLOCK_IRQ        (CLOCK_IRQ)
  );

  // 40 MHz clock
  always #12.5 SYS_CLK = ~SYS_CLK;

  // Single comparison point
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One bus access; reads leave a note for the monitor
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= 4'hf;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    if (!w)
      q.push_back('{nm, e, m});
    @(posedge SYS_CLK iff AVS_WAITREQUEST === 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  // Write d unchanged with all four byte enables set
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0, "");
  endtask

  task automatic rdx(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 32'hffff_ffff, e, nm);
  endtask

  // Poll status until the switch reports the wanted source
  task automatic poll_src(input logic [1:0] s);
    for (int k = 0; k < 40; k++) begin
      bus(1'b0, `CFG_OFFSET, 32'h0, 32'h0, 32'h0, "");
      if (rd[3:2] === s)
        break;
    end
  endtask

  // Interval between bus enable pulses, third one measured
  task automatic per(input bit s, input int e, input string nm);
    int c;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(negedge SYS_CLK);
        c++;
      end while ((s ? SLOW_BUS_EN : FAST_BUS_EN) !== 1'b1 && c < 9000);
    end
    chk(nm, 32'(c), 32'(e));
  endtask

  // Read result monitor, oldest note first
  always @(posedge SYS_CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      n = q.pop_front();
      if (n.m !== 32'h0)
        chk(n.nm, AVS_READDATA & n.m, n.e);
    end
  end

  // Hang guard
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop;
    end
  end

  // Main sequence
  initial begin
    SYS_CLK = 1'b0;
    RST_N = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'h0;
    SOURCE_STABLE = 7'h00;
    CRYSTAL_STUCK = 1'b0;
    LOW_POWER_EXIT = 1'b0;
    LOOP_FROM_CRYSTAL = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(70331));
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(negedge SYS_CLK);
    chk("src_reset", 32'(SYSCLK_SOURCE), 32'h0);
    chk("irq_reset", 32'(CLOCK_IRQ), 32'h0);
    rdx(`INT_OFFSET, `RESET_VALUE, "int_reset");
    rdx(`CFG_OFFSET, 32'h0, "cfg_reset");
    wr(4'hc, 32'hffff_ffff);
    rdx(4'hc, 32'h0, "unmapped");
    $display("test reset done");

    // Stable flags gated by enables, partial and full clear
    en = 7'($urandom) | 7'h01;
    cl = 7'($urandom);
    wr(`INT_OFFSET, {16'h0, 1'b0, en, 8'h0});
    SOURCE_STABLE <= 7'h7f;
    repeat (10) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk("irq_set", 32'(CLOCK_IRQ), 32'h1);
    rdx(`INT_OFFSET, {16'h0, 1'b0, en, 1'b0, en}, "flags_set");
    wr(`INT_OFFSET, {8'h0, 1'b0, cl, 1'b0, en, 8'h0});
    rdx(`INT_OFFSET, {16'h0, 1'b0, en, 1'b0, en & ~cl}, "flags_part");
    wr(`INT_OFFSET, {8'h0, 8'h7f, 1'b0, en, 8'h0});
    rdx(`INT_OFFSET, {16'h0, 1'b0, en, 8'h0}, "flags_clr");
    @(negedge SYS_CLK);
    chk("irq_clr", 32'(CLOCK_IRQ), 32'h0);
    $display("test flags done");

    // Switch to crystal, then loop fed by crystal; crystal failure forces rc8
    for (int s = 1; s < 3; s++) begin
      @(posedge SYS_CLK);
      LOOP_FROM_CRYSTAL <= 1'b1;
      wr(`CFG_OFFSET, 32'(s));
      @(negedge SYS_CLK);
      chk("src_wait", 32'(SYSCLK_SOURCE), 32'h0);
      poll_src(2'(s));
      @(negedge SYS_CLK);
      chk("src_done", 32'(SYSCLK_SOURCE), 32'(s));
      @(posedge SYS_CLK);
      CRYSTAL_STUCK <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk("src_fail", 32'(SYSCLK_SOURCE), 32'h0);
      rdx(`CFG_OFFSET, 32'h0, "sel_fail");
      rdx(`INT_OFFSET, {16'h0, 1'b0, en, 8'h80}, "stuck_set");
      wr(`INT_OFFSET, {8'h0, 8'h80, 1'b0, en, 8'h0});
      rdx(`INT_OFFSET, {16'h0, 1'b0, en, 8'h00}, "stuck_clr");
      CRYSTAL_STUCK <= 1'b0;
      repeat (8) @(posedge SYS_CLK);
    end
    $display("test crystal fail done");

    // Loop source, reserved select code, then wake from low power
    LOOP_FROM_CRYSTAL <= 1'b0;
    wr(`CFG_OFFSET, 32'h2);
    poll_src(2'h2);
    wr(`CFG_OFFSET, 32'h3);
    rdx(`CFG_OFFSET, 32'h0000_000a, "sel_resv");
    @(posedge SYS_CLK);
    LOW_POWER_EXIT <= 1'b1;
    @(posedge SYS_CLK);
    LOW_POWER_EXIT <= 1'b0;
    @(negedge SYS_CLK);
    chk("src_wake", 32'(SYSCLK_SOURCE), 32'h0);
    rdx(`CFG_OFFSET, 32'h0, "sel_wake");
    $display("test wake done");

    // Every fast divider code; slow stays far under 60 MHz at 40 MHz
    for (int f = 0; f < 16; f++) begin
      sl = (f > 11) ? 3'h0 : 3'($urandom);
      wr(`CFG_OFFSET, {21'h0, sl, 4'(f), 4'h0});
      fp = f[3] ? (f[2] ? 2 ** (f[1:0] + 6) : 2 ** (f[1:0] + 1)) : 1;
      sp = sl[2] ? 2 ** (sl[1:0] + 1) : 1;
      per(1'b0, fp, "fast_per");
      per(1'b1, fp * sp, "slow_per");
    end
    $display("test dividers done");
    report_and_stop;
  end
endmodule
`default_nettype wire
